// ==== cfg_shift_ctrl.sv ====
// core-side controller that shifts and commits configuration words
// assumes ref_clk doubles as shift clock; the bench calls load
`timescale 1ns/1ps
module cfg_shift_ctrl #(
  parameter int WBITS = 84
)(
  // clock and echo
  input wire logic ref_clk,
  input wire logic cfg_serial_out,
  // serial port
  output logic cfg_serial_in,
  output logic cfg_shift_enable,
  output logic cfg_update_strobe
);
  logic [83:0] echo_ff = '0;
  initial begin
    cfg_serial_in = 1'b0;
    cfg_shift_enable = 1'b0;
    cfg_update_strobe = 1'b0;
  end
  // gap stalls between bits; bad raises update mid-shift on purpose
  task automatic load(input logic [83:0] w, input int gap, input int hold, input bit bad);
    for (int i = 0; i < WBITS; i++) begin
      @(negedge ref_clk);
      cfg_serial_in = w[i];
      cfg_shift_enable = 1'b1;
      cfg_update_strobe = bad && i == 40;
      @(posedge ref_clk);
      #1 echo_ff[i] = cfg_serial_out;
      if (gap > 0) begin
        @(negedge ref_clk);
        cfg_shift_enable = 1'b0;
        cfg_serial_in = ~w[i];
        repeat (gap - 1) @(negedge ref_clk);
      end
    end
    @(negedge ref_clk);
    cfg_shift_enable = 1'b0;
    cfg_serial_in = ~cfg_serial_in;
    repeat (gap) @(negedge ref_clk);
    cfg_update_strobe = 1'b1;
    repeat (hold) @(negedge ref_clk);
    cfg_update_strobe = 1'b0;
  endtask
endmodule

// ==== cfg_word_map.svh ====
// bit positions, widths and defaults of the clock conditioning configuration word
// assumes inclusion by the package and the design files, one definition set only
`ifndef CFG_WORD_MAP_SVH
`define CFG_WORD_MAP_SVH

`define CFG_BASE_BITS 81
`define CFG_EXT_BITS 84
`define CFG_PREDIV_LSB 0
`define CFG_PREDIV_W 7
`define CFG_LOOPDIV_LSB 7
`define CFG_LOOPDIV_W 7
`define CFG_ODIV_A_LSB 14
`define CFG_ODIV_B_LSB 19
`define CFG_ODIV_C_LSB 24
`define CFG_ODIV_W 5
`define CFG_PHASE_A_LSB 29
`define CFG_PHASE_B_LSB 32
`define CFG_PHASE_C_LSB 35
`define CFG_PHASE_W 3
`define CFG_LOOPSEL_LSB 38
`define CFG_LOOPSEL_W 2
`define CFG_LOOPDLY_LSB 40
`define CFG_DLY_W 5
`define CFG_SYSDLY_BIT 45
`define CFG_GDLY_A_LSB 46
`define CFG_GDLY_B_LSB 51
`define CFG_GDLY_C_LSB 56
`define CFG_CDLY_B_LSB 61
`define CFG_CDLY_C_LSB 66
`define CFG_STAT_A_BIT 71
`define CFG_STAT_B_BIT 72
`define CFG_STAT_C_BIT 73
`define CFG_GEAR_LSB 74
`define CFG_GEAR_W 3
`define CFG_DYN_A_BIT 77
`define CFG_DYN_B_BIT 78
`define CFG_DYN_C_BIT 79
`define CFG_RESYNC_BIT 80
`define CFG_OSC_A_BIT 81
`define CFG_OSC_B_BIT 82
`define CFG_OSC_C_BIT 83
`define CFG_PHASE_BYPASS 3'h0
`define CFG_PHASE_DLYLINE 3'h2
`define CFG_PHASE_P0 3'h4
`define CFG_PHASE_P270 3'h5
`define CFG_PHASE_P180 3'h6
`define CFG_PHASE_P90 3'h7
`define CFG_RESYNC_FIXED 1'h1
`define CFG_RESYNC_PULSE 1'h1

`endif

// ==== cfg_word_pkg.sv ====
// types for the configuration word decoder
// assumes cfg_word_map.svh is on the include path
`include "cfg_word_map.svh"
package cfg_word_pkg;
  typedef logic [`CFG_EXT_BITS-1:0] cfg_word_t;
  typedef enum logic [2:0] {
    phase_bypass, phase_dlyline, phase_p0, phase_p270, phase_p180, phase_p90, phase_invalid
  } phase_kind_t;
  typedef enum logic [1:0] {
    loop_ground, loop_direct, loop_delayed, loop_invalid
  } loop_kind_t;
endpackage

// ==== phase_code_decoder.sv ====
// decodes one three-bit output phase selector code into its kind
// assumes the code comes from a registered configuration word
`timescale 1ns/1ps
`include "cfg_word_map.svh"
module phase_code_decoder
  import cfg_word_pkg::*;
(
  phase_if.dec pi
);
  assign pi.kind = (pi.code == `CFG_PHASE_BYPASS) ? phase_bypass :
                   (pi.code == `CFG_PHASE_DLYLINE) ? phase_dlyline :
                   (pi.code == `CFG_PHASE_P0) ? phase_p0 :
                   (pi.code == `CFG_PHASE_P270) ? phase_p270 :
                   (pi.code == `CFG_PHASE_P180) ? phase_p180 :
                   (pi.code == `CFG_PHASE_P90) ? phase_p90 : phase_invalid;
endmodule

// ==== phase_if.sv ====
// carries one output path's phase code and its decoded kind
// assumes one decoder drives it and the top reads it
`timescale 1ns/1ps
`include "cfg_word_map.svh"
interface phase_if;
  logic [`CFG_PHASE_W-1:0] code;
  cfg_word_pkg::phase_kind_t kind;
  modport dec (input code, output kind);
  modport top (output code, input kind);
endinterface

// ==== pll_cfg_properties.sv ====
// port properties of the configuration word decoder
// assumes binding onto pll_config_word_decoder
`timescale 1ns/1ps
module pll_cfg_props
  import cfg_word_pkg::*;
(
  // clock, reset, controls
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic cfg_shift_enable,
  input wire logic cfg_update_strobe,
  input wire logic cfg_mode_dynamic,
  // decoded fields
  input wire logic [6:0] ref_prediv_field,
  input wire logic [2:0] primary_phase_select,
  input wire logic [2:0] sec2_phase_select,
  input wire phase_kind_t primary_phase_kind,
  input wire phase_kind_t sec2_phase_kind,
  input wire logic [1:0] loop_path_select,
  input wire loop_kind_t loop_path_kind,
  input wire logic divider_resync_enable,
  input wire logic divider_resync_pulse
);
  localparam phase_kind_t KT [8] = '{phase_bypass, phase_invalid, phase_dlyline, phase_invalid, phase_p0,
    phase_p270, phase_p180, phase_p90};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_pulse_single: assert property (divider_resync_pulse && clk_en |=> !divider_resync_pulse)
    else $error("resync pulse too long");
  a_pulse_commit: assert property ($rose(cfg_update_strobe) && !cfg_shift_enable && clk_en
    && cfg_mode_dynamic |=> divider_resync_pulse) else $error("no resync pulse after commit");
  a_pulse_cause: assert property (divider_resync_pulse |-> $past(cfg_mode_dynamic) && $past(cfg_update_strobe))
    else $error("resync pulse without dynamic commit");
  a_busy_refuse: assert property (cfg_update_strobe && cfg_shift_enable |=> !divider_resync_pulse)
    else $error("update taken while shifting");
  a_held_once: assert property (cfg_update_strobe && $past(cfg_update_strobe) && clk_en
    |=> !divider_resync_pulse) else $error("held update committed twice");
  a_resync_fixed: assert property ((cfg_mode_dynamic && clk_en) [*3] |-> divider_resync_enable)
    else $error("resync enable not fixed high");
  a_phase_kind: assert property (primary_phase_kind == KT[primary_phase_select]
    && sec2_phase_kind == KT[sec2_phase_select]) else $error("phase kind mismatch");
  a_loop_kind: assert property (loop_path_kind == loop_kind_t'(loop_path_select))
    else $error("loop kind mismatch");
  a_fields_hold: assert property (($past(arst_n) && clk_en && !cfg_update_strobe && $stable(cfg_mode_dynamic)) [*3]
    |-> $stable(ref_prediv_field)) else $error("field moved without commit");
  c_commit: cover property (divider_resync_pulse);
  c_refused: cover property (cfg_update_strobe && cfg_shift_enable);
  c_static: cover property (!cfg_mode_dynamic && clk_en);
endmodule
bind pll_config_word_decoder pll_cfg_props chk (.ref_clk, .arst_n, .clk_en, .cfg_shift_enable, .cfg_update_strobe,
  .cfg_mode_dynamic, .ref_prediv_field, .primary_phase_select, .sec2_phase_select, .primary_phase_kind,
  .sec2_phase_kind, .loop_path_select, .loop_path_kind, .divider_resync_enable, .divider_resync_pulse);

// ==== pll_config_word_decoder.sv ====
// serial configuration register and field decoder of a clock conditioning block
// assumes shift and update inputs are synchronous to ref_clk, one shift per enabled edge
//
// Overview of operation
// - input reference divider field is bits 6..0, divide by value plus one
// - loop feedback divider field is bits 13..7, divide by value plus one
// - primary output divider is bits 18..14 plus one
// - first secondary output divider is bits 23..19 plus one
// - second secondary output divider is bits 28..24 plus one
// - phase selectors at bits 31..29, 34..32, 37..35
// - bits 39..38 steer feedback multiplexer
// - feedback delay setting is bits 44..40
// - bit 45 inserts fixed system delay into feedback path
// - global output delays at 50..46, 55..51, 60..56
// - secondary core output delays at 65..61 and 70..66
// - input mux selects A, B, C at bits 71, 72, 73
// - vco gear is three bits 76..74
// - bit 77 sets input A for dynamic configuration
// - bit 78 routes input B to first secondary global output
// - bit 79 routes input C to second secondary global output
// - bit 80 high resynchronises output dividers after an update; the code forces it high and pulses in dynamic mode only
// - extended variant: bits 81..83 pick RC or crystal source
// - mode high applies shifted bits, low applies default bits
// - phase codes: 0 bypass, 2 delay line, 4/5/6/7 are 0/270/180/90
`timescale 1ns/1ps
`include "cfg_word_map.svh"
module pll_config_word_decoder
  import cfg_word_pkg::*;
#(
  parameter bit EXTENDED = 1'b0,
  parameter cfg_word_t DEFAULT_WORD = '0
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // serial configuration port
  input wire logic cfg_serial_in,
  input wire logic cfg_shift_enable,
  input wire logic cfg_update_strobe,
  input wire logic cfg_mode_dynamic,
  output logic cfg_serial_out,
  // dividers
  output logic [`CFG_PREDIV_W-1:0] ref_prediv_field,
  output logic [`CFG_LOOPDIV_W-1:0] loop_multiplier_field,
  output logic [`CFG_ODIV_W-1:0] primary_out_divider,
  output logic [`CFG_ODIV_W-1:0] sec1_out_divider,
  output logic [`CFG_ODIV_W-1:0] sec2_out_divider,
  // phase selection
  output logic [`CFG_PHASE_W-1:0] primary_phase_select,
  output logic [`CFG_PHASE_W-1:0] sec1_phase_select,
  output logic [`CFG_PHASE_W-1:0] sec2_phase_select,
  output phase_kind_t primary_phase_kind,
  output phase_kind_t sec1_phase_kind,
  output phase_kind_t sec2_phase_kind,
  // feedback path
  output logic [`CFG_LOOPSEL_W-1:0] loop_path_select,
  output loop_kind_t loop_path_kind,
  output logic [`CFG_DLY_W-1:0] loop_delay_setting,
  output logic system_delay_insert,
  // output delays
  output logic [`CFG_DLY_W-1:0] primary_global_delay,
  output logic [`CFG_DLY_W-1:0] sec1_global_delay,
  output logic [`CFG_DLY_W-1:0] sec2_global_delay,
  output logic [`CFG_DLY_W-1:0] sec1_core_delay,
  output logic [`CFG_DLY_W-1:0] sec2_core_delay,
  // input selection
  output logic input_a_mux_select,
  output logic input_b_mux_select,
  output logic input_c_mux_select,
  output logic [`CFG_GEAR_W-1:0] vco_gear,
  output logic input_a_dynamic_route,
  output logic input_b_dynamic_route,
  output logic input_c_dynamic_route,
  output logic input_a_osc_source,
  output logic input_b_osc_source,
  output logic input_c_osc_source,
  // divider resync
  output logic divider_resync_enable,
  output logic divider_resync_pulse
);

  localparam int WBITS = EXTENDED ? `CFG_EXT_BITS : `CFG_BASE_BITS;
  // fixed bit from reset
  // dynamic mode before the first commit must still read resync enabled
  localparam cfg_word_t DYN_RESET = cfg_word_t'(`CFG_RESYNC_FIXED) << `CFG_RESYNC_BIT;

  cfg_word_t shift_ff;
  cfg_word_t nxt_shift;
  cfg_word_t dyn_ff;
  cfg_word_t nxt_dyn;
  cfg_word_t act_ff;
  cfg_word_t sel_word;
  logic sout_ff;
  logic resync_ff;
  logic upd_ff;
  logic upd_rise;
  logic upd_commit;
  phase_kind_t pk_a_ff;
  phase_kind_t pk_b_ff;
  phase_kind_t pk_c_ff;
  loop_kind_t lk_ff;
  loop_kind_t loop_kind_w;

  phase_if pa();
  phase_if pb();
  phase_if pc();

  // lsb-first shift chain
  // new bit enters at the top so the first bit ends at bit 0 after WBITS shifts
  always_comb begin
    nxt_shift = shift_ff >> 1;
    nxt_shift[WBITS-1] = cfg_serial_in;
  end

  // update only outside shifting
  // update is taken on its rising edge, so a held strobe commits once
  assign upd_rise = cfg_update_strobe & ~upd_ff;
  assign upd_commit = upd_rise & ~cfg_shift_enable;

  // resync bit forced fixed
  // extension bits are cleared from the shifted word on the base variant
  always_comb begin
    nxt_dyn = shift_ff;
    nxt_dyn[`CFG_RESYNC_BIT] = `CFG_RESYNC_FIXED;
    if (!EXTENDED) begin
      nxt_dyn[`CFG_OSC_C_BIT:`CFG_OSC_A_BIT] = '0;
    end
  end

  assign sel_word = cfg_mode_dynamic ? dyn_ff : DEFAULT_WORD;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= '0;
      sout_ff <= 1'b0;
    end else if (clk_en && cfg_shift_enable) begin
      shift_ff <= nxt_shift;
      sout_ff <= shift_ff[0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      upd_ff <= 1'b0;
      dyn_ff <= DYN_RESET;
    end else if (clk_en) begin
      upd_ff <= cfg_update_strobe;
      if (upd_commit) begin
        dyn_ff <= nxt_dyn;
      end
    end
  end

  // resync pulse after update
  // pulse follows the committed update by one cycle, gated by the mode and the committed word's resync bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resync_ff <= 1'b0;
    end else if (clk_en) begin
      resync_ff <= upd_commit & cfg_mode_dynamic & nxt_dyn[`CFG_RESYNC_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_ff <= '0;
    end else if (clk_en) begin
      act_ff <= sel_word;
    end
  end

  assign pa.code = sel_word[`CFG_PHASE_A_LSB +: `CFG_PHASE_W];
  assign pb.code = sel_word[`CFG_PHASE_B_LSB +: `CFG_PHASE_W];
  assign pc.code = sel_word[`CFG_PHASE_C_LSB +: `CFG_PHASE_W];

  phase_code_decoder u_pa (.pi(pa));
  phase_code_decoder u_pb (.pi(pb));
  phase_code_decoder u_pc (.pi(pc));

  assign loop_kind_w = loop_kind_t'(sel_word[`CFG_LOOPSEL_LSB +: `CFG_LOOPSEL_W]);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pk_a_ff <= phase_bypass;
      pk_b_ff <= phase_bypass;
      pk_c_ff <= phase_bypass;
      lk_ff <= loop_ground;
    end else if (clk_en) begin
      pk_a_ff <= pa.kind;
      pk_b_ff <= pb.kind;
      pk_c_ff <= pc.kind;
      lk_ff <= loop_kind_w;
    end
  end

  // field extraction, fields straight from the active word register, kinds, echo and pulse from their own flops
  assign cfg_serial_out = sout_ff;
  assign ref_prediv_field = act_ff[`CFG_PREDIV_LSB +: `CFG_PREDIV_W];
  assign loop_multiplier_field = act_ff[`CFG_LOOPDIV_LSB +: `CFG_LOOPDIV_W];
  assign primary_out_divider = act_ff[`CFG_ODIV_A_LSB +: `CFG_ODIV_W];
  assign sec1_out_divider = act_ff[`CFG_ODIV_B_LSB +: `CFG_ODIV_W];
  assign sec2_out_divider = act_ff[`CFG_ODIV_C_LSB +: `CFG_ODIV_W];
  assign primary_phase_select = act_ff[`CFG_PHASE_A_LSB +: `CFG_PHASE_W];
  assign sec1_phase_select = act_ff[`CFG_PHASE_B_LSB +: `CFG_PHASE_W];
  assign sec2_phase_select = act_ff[`CFG_PHASE_C_LSB +: `CFG_PHASE_W];
  assign primary_phase_kind = pk_a_ff;
  assign sec1_phase_kind = pk_b_ff;
  assign sec2_phase_kind = pk_c_ff;
  assign loop_path_select = act_ff[`CFG_LOOPSEL_LSB +: `CFG_LOOPSEL_W];
  assign loop_path_kind = lk_ff;
  assign loop_delay_setting = act_ff[`CFG_LOOPDLY_LSB +: `CFG_DLY_W];
  assign system_delay_insert = act_ff[`CFG_SYSDLY_BIT];
  assign primary_global_delay = act_ff[`CFG_GDLY_A_LSB +: `CFG_DLY_W];
  assign sec1_global_delay = act_ff[`CFG_GDLY_B_LSB +: `CFG_DLY_W];
  assign sec2_global_delay = act_ff[`CFG_GDLY_C_LSB +: `CFG_DLY_W];
  assign sec1_core_delay = act_ff[`CFG_CDLY_B_LSB +: `CFG_DLY_W];
  assign sec2_core_delay = act_ff[`CFG_CDLY_C_LSB +: `CFG_DLY_W];
  assign input_a_mux_select = act_ff[`CFG_STAT_A_BIT];
  assign input_b_mux_select = act_ff[`CFG_STAT_B_BIT];
  assign input_c_mux_select = act_ff[`CFG_STAT_C_BIT];
  assign vco_gear = act_ff[`CFG_GEAR_LSB +: `CFG_GEAR_W];
  assign input_a_dynamic_route = act_ff[`CFG_DYN_A_BIT];
  assign input_b_dynamic_route = act_ff[`CFG_DYN_B_BIT];
  assign input_c_dynamic_route = act_ff[`CFG_DYN_C_BIT];
  assign input_a_osc_source = act_ff[`CFG_OSC_A_BIT];
  assign input_b_osc_source = act_ff[`CFG_OSC_B_BIT];
  assign input_c_osc_source = act_ff[`CFG_OSC_C_BIT];
  assign divider_resync_enable = act_ff[`CFG_RESYNC_BIT];
  assign divider_resync_pulse = resync_ff;

endmodule

// ==== tb_top.sv ====
// self-checking bench for the configuration word decoder
// assumes the controller model and bound checker are compiled with it
`timescale 1ns/1ps
module tb_top
  import cfg_word_pkg::*;
;
  localparam cfg_word_t DEF = 84'hA_6D2C_A5F3_1E87_94D0_3C6A;
  localparam cfg_word_t W1 = 84'h4_F0E1_D2C3_B4A5_9687_7869;
  localparam cfg_word_t W2 = 84'h3_1234_5678_9ABC_DEF0_2468;
  localparam phase_kind_t KT [8] = '{phase_bypass, phase_invalid, phase_dlyline, phase_invalid, phase_p0,
    phase_p270, phase_p180, phase_p90};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cfg_mode_dynamic = 1'b0;
  logic cfg_serial_in, cfg_shift_enable, cfg_update_strobe, cfg_serial_out, pulse;
  wire logic [83:0] obs;
  phase_kind_t pk [3];
  loop_kind_t lk;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  cfg_shift_ctrl #(.WBITS(84)) u_ctrl (.ref_clk, .cfg_serial_out, .cfg_serial_in, .cfg_shift_enable,
    .cfg_update_strobe);
  pll_config_word_decoder #(.EXTENDED(1'b1), .DEFAULT_WORD(DEF)) dut (.ref_clk, .arst_n, .clk_en, .cfg_serial_in,
    .cfg_shift_enable, .cfg_update_strobe, .cfg_mode_dynamic, .cfg_serial_out,
    .ref_prediv_field(obs[6:0]), .loop_multiplier_field(obs[13:7]), .primary_out_divider(obs[18:14]),
    .sec1_out_divider(obs[23:19]), .sec2_out_divider(obs[28:24]), .primary_phase_select(obs[31:29]),
    .sec1_phase_select(obs[34:32]), .sec2_phase_select(obs[37:35]), .primary_phase_kind(pk[0]),
    .sec1_phase_kind(pk[1]), .sec2_phase_kind(pk[2]), .loop_path_select(obs[39:38]), .loop_path_kind(lk),
    .loop_delay_setting(obs[44:40]), .system_delay_insert(obs[45]), .primary_global_delay(obs[50:46]),
    .sec1_global_delay(obs[55:51]), .sec2_global_delay(obs[60:56]), .sec1_core_delay(obs[65:61]),
    .sec2_core_delay(obs[70:66]), .input_a_mux_select(obs[71]), .input_b_mux_select(obs[72]),
    .input_c_mux_select(obs[73]), .vco_gear(obs[76:74]), .input_a_dynamic_route(obs[77]),
    .input_b_dynamic_route(obs[78]), .input_c_dynamic_route(obs[79]), .divider_resync_enable(obs[80]),
    .input_a_osc_source(obs[81]), .input_b_osc_source(obs[82]), .input_c_osc_source(obs[83]),
    .divider_resync_pulse(pulse));
  task automatic cmp(input logic [83:0] got, input logic [83:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ceiling well above the roughly 1240 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  // a held update leaves the pulse already gone on return
  task automatic t_load(input cfg_word_t w, input int gap, input int hold, input bit bad);
    u_ctrl.load(w, gap, hold, bad);
    cmp({83'h0, pulse}, {83'h0, hold == 1});
    @(negedge ref_clk);
    cmp(obs, {w[83:81], 1'b1, w[79:0]});
  endtask
  task automatic t_phase();
    cfg_word_t w;
    for (int c = 0; c < 8; c++) begin
      w = W2;
      w[39:29] = {c[1:0], c[2:0], c[2:0], c[2:0]};
      t_load(w, 0, 1, 1'b0);
      cmp({73'h0, lk, pk[2], pk[1], pk[0]}, {73'h0, c[1:0], KT[c], KT[c], KT[c]});
    end
  endtask
  // mode change while frozen must wait for clk_en
  task automatic t_mode(input cfg_word_t last);
    cfg_mode_dynamic = 1'b0;
    repeat (2) @(negedge ref_clk);
    cmp(obs, DEF);
    clk_en = 1'b0;
    cfg_mode_dynamic = 1'b1;
    repeat (3) @(negedge ref_clk);
    cmp(obs, DEF);
    clk_en = 1'b1;
    repeat (2) @(negedge ref_clk);
    cmp(obs, {last[83:81], 1'b1, last[79:0]});
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    cmp(obs, DEF);
    cfg_mode_dynamic = 1'b1;
    t_load(W1, 0, 1, 1'b0);
    t_load(W2, 3, 1, 1'b1);
    cmp(u_ctrl.echo_ff, W1);
    t_phase();
    t_load(W1, 0, 3, 1'b0);
    t_mode(W1);
    stop_test();
  end
endmodule
